// file: core/rccs_core.v
`timescale 1ns/100ps
`include "rccs_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Trap conflict sets bit 15
// - Illegal op or W access sets 14
// - Configuration mismatch sets bit 9
// - Master clear reset sets bit 7
// - Software reset instruction sets bit 6
// - Watchdog sets bit 4; power-save clears
// - Sleep operand sets bit 3
// - Idle operand sets bit 2
// - Power-on or brown-out sets bit 1
// - Software may set or clear flags
// - No switching: clock from config bits
// - Switching: cold from initial, warm current
// - System reset after power-on and timer
// - Oscillator waits parallel; execution waits all
// - Clock monitor starts after its delay
// - Any reset clears and fetches at zero
module rccs_core #(
    parameter POR_CYC = (`RCCS_POR_US * `RCCS_CLK_MHZ),
    parameter POWER_UP_TIMER_CYC = (`RCCS_POWER_UP_TIMER_US * `RCCS_CLK_MHZ),
    parameter OST_CYC = (`RCCS_OST_US * `RCCS_CLK_MHZ),
    parameter CLOCK_FAIL_MONITOR_CYC = (`RCCS_CLOCK_FAIL_MONITOR_US * `RCCS_CLK_MHZ),
    parameter CW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire brownout_evt,
    input wire master_clear_evt,
    input wire watchdog_evt,
    input wire sw_reset_evt,
    input wire trap_conflict_evt,
    input wire illegal_op_evt,
    input wire config_mismatch_evt,
    input wire power_save_sleep_evt,
    input wire power_save_idle_evt,
    input wire [2:0] initial_osc_select,
    input wire [2:0] current_osc_select,
    input wire osc_ready,
    input wire pll_lock,
    output reg system_reset,
    output reg cpu_run,
    output reg clock_fail_monitor_en,
    output reg [2:0] clk_source_sel,
    output reg [23:0] reset_pc,
    output wire irq
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_POR = 2'd0;
localparam ST_POWER_UP_TIMER = 2'd1;
localparam ST_WAIT = 2'd2;
localparam ST_RUN = 2'd3;

reg [15:0] cause;
reg [15:0] mask;
reg [15:0] pend;
reg [7:0] ctrl;
reg [1:0] state;
reg [CW-1:0] seq_cnt;
reg [CW-1:0] ost_cnt;
reg [CW-1:0] clock_fail_monitor_cnt;
reg ost_done;
reg [15:0] evt;
reg [15:0] next_cause;
reg [15:0] wr_val;
reg warm_rst;

wire wr_en = psel & penable & pwrite;
wire rd_en = psel & penable & ~pwrite;
wire hit = (paddr == `RCCS_OFF_CAUSE) | (paddr == `RCCS_OFF_MASK) | (paddr == `RCCS_OFF_PEND) |
    (paddr == `RCCS_OFF_CTRL) | (paddr == `RCCS_OFF_STAT);
assign pready = 1'b1;
assign pslverr = psel & penable & ~hit;
assign irq = |(pend & mask);

////////////////////////////////////////////////////////////////////////////////
// Event vector in flag layout
always @* begin
    evt = 16'h0000;
    evt[`RCCS_B_TRAP] = trap_conflict_evt;
    evt[`RCCS_B_ILLOP] = illegal_op_evt;
    evt[`RCCS_B_CFGMM] = config_mismatch_evt;
    evt[`RCCS_B_EXT_PIN_RESET_FLAG] = master_clear_evt;
    evt[`RCCS_B_SWR] = sw_reset_evt;
    evt[`RCCS_B_WATCHDOG_TIMEOUT_FLAG] = watchdog_evt;
    evt[`RCCS_B_SLEEP] = power_save_sleep_evt;
    evt[`RCCS_B_IDLE] = power_save_idle_evt;
    evt[`RCCS_B_BOR] = brownout_evt;
end

// Software write first, then hardware clear, then set; set wins over all
always @* begin
    wr_val = pwdata[15:0] & `RCCS_CAUSE_MASK;
    next_cause = cause;
    if (wr_en && paddr == `RCCS_OFF_CAUSE) begin
        next_cause = wr_val;
    end
    if (power_save_sleep_evt | power_save_idle_evt) begin
        next_cause[`RCCS_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    end
    next_cause = next_cause | evt;
end

always @* begin
    warm_rst = master_clear_evt | watchdog_evt | sw_reset_evt | trap_conflict_evt |
        illegal_op_evt | config_mismatch_evt;
end

////////////////////////////////////////////////////////////////////////////////
// presetn is the power-on reset: it clears every cause but BOR and POR
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cause <= `RCCS_CAUSE_RST;
        mask <= 16'h0000;
        ctrl <= 8'h00;
    end else begin
        cause <= next_cause;
        if (wr_en && paddr == `RCCS_OFF_MASK) begin
            mask <= pwdata[15:0] & `RCCS_CAUSE_MASK;
        end
        if (wr_en && paddr == `RCCS_OFF_CTRL) begin
            ctrl <= pwdata[7:0];
        end
    end
end

// Pending copy of events for the interrupt; a read clears only what it returned,
// so an event landing in the setup cycle is not lost, and a new event wins
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pend <= `RCCS_CAUSE_RST;
    end else if (rd_en && paddr == `RCCS_OFF_PEND) begin
        pend <= (pend & ~prdata[15:0]) | evt;
    end else begin
        pend <= pend | evt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Reset sequencer; brown-out and warm resets restart it
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state <= ST_POR;
        seq_cnt <= {CW{1'b0}};
        ost_cnt <= {CW{1'b0}};
        ost_done <= 1'b0;
        clock_fail_monitor_cnt <= {CW{1'b0}};
        system_reset <= 1'b1;
        cpu_run <= 1'b0;
        clock_fail_monitor_en <= 1'b0;
        clk_source_sel <= 3'h0;
        reset_pc <= 24'h000000;
    end else if (brownout_evt | warm_rst) begin
        state <= brownout_evt ? ST_POR : ST_POWER_UP_TIMER;
        seq_cnt <= {CW{1'b0}};
        ost_cnt <= {CW{1'b0}};
        ost_done <= 1'b0;
        clock_fail_monitor_cnt <= {CW{1'b0}};
        system_reset <= 1'b1;
        cpu_run <= 1'b0;
        clock_fail_monitor_en <= 1'b0;
        reset_pc <= 24'h000000;
        if (!ctrl[`RCCS_CTRL_SWEN]) begin
            clk_source_sel <= ctrl[`RCCS_CTRL_CFG_MSB:`RCCS_CTRL_CFG_LSB];
        end else if (brownout_evt) begin
            clk_source_sel <= initial_osc_select;
        end else begin
            clk_source_sel <= current_osc_select;
        end
    end else begin
        // Oscillator start-up runs beside the reset delays
        if (!ost_done) begin
            if (ost_cnt >= OST_CYC[CW-1:0] - 1'b1 && osc_ready && pll_lock) begin
                ost_done <= 1'b1;
            end else if (ost_cnt < OST_CYC[CW-1:0] - 1'b1) begin
                ost_cnt <= ost_cnt + 1'b1;
            end
        end
        case (state)
            ST_POR: begin
                if (seq_cnt == POR_CYC[CW-1:0] - 1'b1) begin
                    seq_cnt <= {CW{1'b0}};
                    state <= ST_POWER_UP_TIMER;
                end else begin
                    seq_cnt <= seq_cnt + 1'b1;
                end
                if (seq_cnt == {CW{1'b0}} && !ctrl[`RCCS_CTRL_SWEN]) begin
                    clk_source_sel <= ctrl[`RCCS_CTRL_CFG_MSB:`RCCS_CTRL_CFG_LSB];
                end else if (seq_cnt == {CW{1'b0}}) begin
                    clk_source_sel <= initial_osc_select;
                end
            end
            ST_POWER_UP_TIMER: begin
                if (seq_cnt == POWER_UP_TIMER_CYC[CW-1:0] - 1'b1) begin
                    seq_cnt <= {CW{1'b0}};
                    system_reset <= 1'b0;
                    state <= ST_WAIT;
                end else begin
                    seq_cnt <= seq_cnt + 1'b1;
                end
            end
            ST_WAIT: begin
                if (ost_done) begin
                    cpu_run <= 1'b1;
                    state <= ST_RUN;
                end
            end
            ST_RUN: begin
                cpu_run <= 1'b1;
            end
            default: begin
                state <= ST_POR;
            end
        endcase
        // Monitor delay counts from system reset release
        if (!system_reset && !clock_fail_monitor_en) begin
            if (clock_fail_monitor_cnt == CLOCK_FAIL_MONITOR_CYC[CW-1:0] - 1'b1) begin
                clock_fail_monitor_en <= 1'b1;
            end else begin
                clock_fail_monitor_cnt <= clock_fail_monitor_cnt + 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data registered in setup phase so it is valid in access phase
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
        case (paddr)
            `RCCS_OFF_CAUSE: prdata <= {16'h0000, cause};
            `RCCS_OFF_MASK: prdata <= {16'h0000, mask};
            `RCCS_OFF_PEND: prdata <= {16'h0000, pend};
            `RCCS_OFF_CTRL: prdata <= {24'h000000, ctrl};
            `RCCS_OFF_STAT: prdata <= {24'h000000, 1'b0, clk_source_sel, ost_done,
                clock_fail_monitor_en, cpu_run, system_reset};
            default: prdata <= 32'h00000000;
        endcase
    end
end

endmodule

// file: core/rccs_map.vh
`ifndef RCCS_MAP_VH
`define RCCS_MAP_VH
// Register byte offsets
`define RCCS_OFF_CAUSE 12'h000
`define RCCS_OFF_MASK 12'h004
`define RCCS_OFF_PEND 12'h008
`define RCCS_OFF_CTRL 12'h00c
`define RCCS_OFF_STAT 12'h010
// Cause flag positions
`define RCCS_B_TRAP 15
`define RCCS_B_ILLOP 14
`define RCCS_B_CFGMM 9
`define RCCS_B_EXT_PIN_RESET_FLAG 7
`define RCCS_B_SWR 6
`define RCCS_B_WATCHDOG_TIMEOUT_FLAG 4
`define RCCS_B_SLEEP 3
`define RCCS_B_IDLE 2
`define RCCS_B_BOR 1
`define RCCS_B_POR 0
// Implemented flag mask and power-on value
`define RCCS_CAUSE_MASK 16'hc2df
`define RCCS_CAUSE_RST 16'h0003
// Control fields
`define RCCS_CTRL_SWEN 0
`define RCCS_CTRL_CFG_LSB 4
`define RCCS_CTRL_CFG_MSB 6
// Delays in microseconds, clock in MHz
`define RCCS_POR_US 10
`define RCCS_POWER_UP_TIMER_US 64
`define RCCS_OST_US 100
`define RCCS_CLOCK_FAIL_MONITOR_US 2
`define RCCS_CLK_MHZ 40
`endif

// file: tb/rccs_asserts.sv
`timescale 1ns/100ps
module rccs_asserts (
    input wire pclk,
    input wire presetn,
    input wire brownout_evt,
    input wire master_clear_evt,
    input wire osc_ready,
    input wire pll_lock,
    input wire pready,
    input wire system_reset,
    input wire cpu_run,
    input wire clock_fail_monitor_en,
    input wire [23:0] reset_pc
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_pc_zero: assert property (reset_pc == 24'h0)
        else $error("restart address not zero");
    chk_reset_span: assert property ($fell(system_reset) |-> $past(system_reset, 8))
        else $error("system reset released too early");
    chk_run_gate: assert property ($rose(cpu_run) |-> !system_reset && $past(osc_ready && pll_lock))
        else $error("execution began before clock was ready");
    chk_run_off: assert property (system_reset ##1 system_reset |-> !cpu_run)
        else $error("execution during system reset");
    chk_monitor_late: assert property (system_reset |=> !clock_fail_monitor_en [*2])
        else $error("clock monitor started without its delay");
    chk_bor_hold: assert property (brownout_evt |=> system_reset [*8])
        else $error("brown-out did not hold system reset");
    chk_warm_hold: assert property (master_clear_evt |=> system_reset [*6])
        else $error("pin reset did not hold system reset");
    chk_ready_high: assert property (pready)
        else $error("wait state inserted");
    cover property ($rose(cpu_run));
    cover property ($rose(clock_fail_monitor_en));
    cover property (master_clear_evt ##1 system_reset);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind rccs_core rccs_asserts u_chk (.*);

// file: tb/reset_cause_and_clock_select_tb.sv
`timescale 1ns/100ps
module reset_cause_and_clock_select_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc_ready = 0, pll_lock = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, q, exp_v;
    logic [8:0] ev = 0;
    logic [2:0] initial_osc_select = 3'h3, current_osc_select = 3'h6;
    wire [31:0] prdata;
    wire pready, pslverr, system_reset, cpu_run, clock_fail_monitor_en, irq;
    wire [2:0] clk_source_sel;
    wire [23:0] reset_pc;
    wire trap_conflict_evt = ev[0], illegal_op_evt = ev[1], config_mismatch_evt = ev[2];
    wire master_clear_evt = ev[3], sw_reset_evt = ev[4], power_save_sleep_evt = ev[5];
    wire power_save_idle_evt = ev[6], watchdog_evt = ev[7], brownout_evt = ev[8];
    int num_errors = 0, tests_run = 0, pos[9] = '{15, 14, 9, 7, 6, 3, 2, 4, 1};
    always #12.5 pclk = ~pclk;
    rccs_core #(.POR_CYC(4), .POWER_UP_TIMER_CYC(8), .OST_CYC(6), .CLOCK_FAIL_MONITOR_CYC(3)) dut (.*);
    ////////////////////////////////////////////////////////////////////////////
    task stop_test;
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task hang;
        num_errors++;
        stop_test;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task bus(input w, input [11:0] a, input [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 1 || pready !== 1'b1; n++) begin
            if (n > 20) hang;
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task pulse(input int i);
        @(posedge pclk) ev[i] <= 1;
        @(posedge pclk) ev <= 0;
        @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_boot;
        int n;
        bus(0, 12'h000, 0); chk(q, 32'h3);
        for (n = 0; system_reset !== 1'b0; n++) begin
            if (n > 50) hang;
            @(posedge pclk);
        end
        // Oscillator held back so execution must wait on it, not on the reset timers
        repeat (8) @(posedge pclk);
        chk(cpu_run, 0);
        osc_ready <= 1; pll_lock <= 1;
        for (n = 0; cpu_run !== 1'b1 || clock_fail_monitor_en !== 1'b1; n++) begin
            if (n > 50) hang;
            @(posedge pclk);
        end
        chk(reset_pc, 0);
        bus(0, 12'h010, 0); chk(q, 32'h0e);
    endtask
    task t_causes;
        bus(1, 12'h000, 0); bus(0, 12'h000, 0); chk(q, 0);
        exp_v = 0;
        for (int i = 0; i < 9; i++) begin
            pulse(i);
            exp_v[pos[i]] = 1;
            bus(0, 12'h000, 0); chk(q, exp_v);
        end
        pulse(5); exp_v[4] = 0;
        bus(0, 12'h000, 0); chk(q, exp_v);
        bus(1, 12'h000, 32'hc2df); bus(0, 12'h000, 0); chk(q, 32'hc2df);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        bus(0, 12'h000, 0); chk(q, 32'h3);
    endtask
    task t_irq;
        bus(1, 12'h004, 1); @(posedge pclk); chk(irq, 1);
        bus(0, 12'h008, 0); chk(q, 32'h3); @(posedge pclk); chk(irq, 0);
        pulse(0); chk(irq, 0);
        bus(1, 12'h004, 32'h8000); @(posedge pclk); chk(irq, 1);
        bus(0, 12'h020, 0); chk(err, 1); chk(q, 0);
    endtask
    task t_clk;
        bus(1, 12'h00c, 32'h50); pulse(8); chk(clk_source_sel, 5);
        bus(1, 12'h00c, 32'h51); pulse(3); chk(clk_source_sel, 6);
        pulse(8); chk(clk_source_sel, 3);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_boot;
        t_causes;
        t_irq;
        t_clk;
        stop_test;
    end
endmodule
